// ==== verilog/ehcr_regs.svh ====
// constants for the error-history and capacity command interpreter
`ifndef EHCR_REGS_SVH
`define EHCR_REGS_SVH

// operation codes and modes
`define OP_READ_BUFFER 8'h3c
`define OP_READ_CAP10 8'h25
`define MODE_ERR_HIST 5'h1c

// buffer id map
`define ID_DIR_LAST 8'h03
`define ID_DIR_SNAP 8'h01
`define ID_DIR_NEXUS 8'h02
`define ID_DIR_BOTH 8'h03
`define ID_HIST_FIRST 8'h10
`define ID_HIST_MAX 8'hef
`define ID_CLR_NEXUS 8'hfe
`define ID_CLR_ALL 8'hff

// history buffers
`define HIST_NUM_BUF 4
`define HIST_BUF_LEN 9'h100
`define HIST_ADDR_W 10
`define OFFSET_MAX 24'h00ffff

// directory layout
`define DIR_ENTRIES 8
`define DIR_HDR_BYTES 9'h020
`define DIR_BYTES 9'h060
`define DIR_LEN_LO 8'h40
`define DIR_VERSION 8'h00
`define DIR_POS_VERSION 9'h008
`define DIR_POS_FLAGS 9'h009
`define DIR_POS_LEN_HI 9'h01e
`define DIR_POS_LEN_LO 9'h01f
`define FLAG_RETRIEVED_BIT 3
`define FLAG_SOURCE_LSB 1
`define FLAG_CLEAR_SUPPORTED_FLAG_BIT 0
`define SRC_BY_HOST 2'h1

// capacity reply
`define CAP_BYTES 9'h008

// sense data
`define SK_ILLEGAL_REQ 4'h5
`define ASC_INVALID_CDB 8'h24
`define ASC_INVALID_OP 8'h20
`define ASC_OIP 8'h00
`define ASCQ_OIP 8'h16

`endif

// ==== verilog/ehcr_pkg.sv ====
// types for the error-history and capacity command interpreter
`default_nettype none
package ehcr_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_DONE} state_t;
  typedef enum logic [1:0] {SRC_DIR, SRC_HIST, SRC_CAP} src_t;
endpackage
`default_nettype wire

// ==== verilog/hist_port_if.sv ====
// write and read port of the error-history store
`timescale 1ns/100ps
`default_nettype none
interface hist_port_if;
  logic wr_en;
  logic [9:0] wr_addr;
  logic [7:0] wr_data;
  logic [9:0] rd_addr;
  logic [7:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface
`default_nettype wire

// ==== verilog/hist_store.sv ====
// error-history byte store, one fixed-size area per history buffer
`timescale 1ns/100ps
`default_nettype none
module hist_store (
  // clock
  input wire logic clk,
  // access port
  hist_port_if.mem port
);
  logic [7:0] mem [0:1023];

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  // asynchronous read; the caller registers the byte
  assign port.rd_data = mem[port.rd_addr];
endmodule
`default_nettype wire

// ==== verilog/word_byte_sel.sv ====
// picks one byte of a 32-bit word, most significant first
`timescale 1ns/100ps
`default_nettype none
module word_byte_sel (
  // word and byte index
  input wire logic [31:0] word,
  input wire logic [1:0] idx,
  // selected byte
  output logic [7:0] byte_out
);
  always_comb begin
    unique case (idx)
      2'h0: byte_out = word[31:24];
      2'h1: byte_out = word[23:16];
      2'h2: byte_out = word[15:8];
      2'h3: byte_out = word[7:0];
    endcase
  end
endmodule
`default_nettype wire

// ==== verilog/ehcr_cmd.sv ====
// command interpreter for error-history buffer reads and the ten-byte capacity read
// Function
// - a constrained error-history read from a foreign nexus while a snapshot exists ends with operation in progress.
// - returned data starts at the buffer offset counted from the start of the selected buffer.
// - an offset not allowed for the buffer id ends the command with invalid field in the command block.
// - every directory action returns the error history directory when the nexus constraints allow it.
// - the directory holds vendor id, version, flag byte, reserved bytes, length n-31 and entries from byte 32.
// - the directory lists exactly one entry per supported buffer id between 00h and EFh.
// - each entry holds the id, three reserved bytes and the big-endian maximum length of the buffer.
// - without error, history bytes come from the selected buffer's area of the store, frozen only while a snapshot exists, starting at the requested offset.
// - an unsupported buffer id from the established nexus ends with invalid field in the command block.
// - no buffer ever holds more history than its listed maximum length.
// - the capacity read with code 25h reports the last logical block address.
// - the capacity reply is data-in, address in bytes 0-3 and block length in bytes 4-7, both msb first.
// - the block length counts user bytes only, without protection information.
// - ids 00h-03h return the directory, 01h-03h with snapshot or nexus side effects, 10h-13h history, FEh and FFh clear.
`timescale 1ns/100ps
`default_nettype none
`include "ehcr_regs.svh"
module ehcr_cmd import ehcr_pkg::*; #(
  parameter logic [63:0] VENDOR_ID = 64'h5645_4e44_4f52_2020 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [4:0] cmd_mode,
  input wire logic [7:0] cmd_buffer_id,
  input wire logic [23:0] cmd_buffer_offset,
  input wire logic [23:0] cmd_alloc_len,
  input wire logic [7:0] cmd_nexus,
  // data-in stream
  output logic din_valid,
  output logic [7:0] din_data,
  output logic din_last,
  input wire logic din_ready,
  // completion
  output logic done,
  output logic check_condition,
  output logic [3:0] sense_key,
  output logic [7:0] sense_asc,
  output logic [7:0] sense_ascq,
  // capacity
  input wire logic [31:0] max_lba,
  input wire logic [31:0] block_length,
  // history fill
  input wire logic hist_wr_valid,
  output logic hist_wr_ready,
  input wire logic [9:0] hist_wr_addr,
  input wire logic [7:0] hist_wr_data,
  // status
  output logic snapshot_valid,
  output logic nexus_valid,
  output logic snapshot_retrieved_flag
);
  state_t state_q;
  src_t src_q;
  logic [8:0] pos_q;
  logic [8:0] cnt_q;
  logic [1:0] buf_q;
  logic din_valid_q, din_last_q;
  logic [7:0] din_data_q;
  logic check_q;
  logic [3:0] key_q;
  logic [7:0] asc_q, ascq_q;
  logic snap_q, nexus_q, retrieved_q;
  logic [7:0] nexus_id_q;
  logic [1:0] snapshot_source_field;
  logic clear_supported_flag;
  hist_port_if hp ();

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic fire, is_rb, is_cap, is_dir, is_hist, is_clr, constrained;
  logic oip_c, bad_op_c, bad_id_c, bad_off_c, err_c;
  logic [8:0] avail_c, len_c;
  logic [7:0] hist_idx;
  logic [23:0] alloc_c;

  assign fire = cmd_valid && cmd_ready;
  assign is_rb = cmd_opcode == `OP_READ_BUFFER && cmd_mode == `MODE_ERR_HIST;
  assign is_cap = cmd_opcode == `OP_READ_CAP10;
  assign hist_idx = cmd_buffer_id - `ID_HIST_FIRST;
  assign is_dir = cmd_buffer_id <= `ID_DIR_LAST;
  assign is_hist = cmd_buffer_id >= `ID_HIST_FIRST && hist_idx < 8'(`HIST_NUM_BUF);
  assign is_clr = cmd_buffer_id == `ID_CLR_NEXUS || cmd_buffer_id == `ID_CLR_ALL;
  assign constrained = !(cmd_buffer_id == `ID_DIR_NEXUS || cmd_buffer_id == `ID_DIR_BOTH);
  assign oip_c = is_rb && constrained && nexus_q && cmd_nexus != nexus_id_q && snap_q;
  assign bad_op_c = !is_rb && !is_cap;
  assign bad_id_c = is_rb && !(is_dir || is_hist || is_clr);
  // offsets past the area cannot be served, so they are refused too
  assign bad_off_c = is_rb && ((is_dir && cmd_buffer_offset != 24'h000000) ||
    (is_hist && (cmd_buffer_offset > `OFFSET_MAX || cmd_buffer_offset >= 24'(`HIST_BUF_LEN))));
  assign err_c = oip_c || bad_op_c || bad_id_c || bad_off_c;

  always_comb begin
    if (is_cap) begin
      avail_c = `CAP_BYTES;
    end else if (is_dir) begin
      avail_c = `DIR_BYTES;
    end else if (is_hist) begin
      avail_c = `HIST_BUF_LEN - cmd_buffer_offset[8:0];
    end else begin
      avail_c = 9'h000;
    end
  end

  // capacity read carries no allocation length of its own
  assign alloc_c = is_cap ? 24'(`CAP_BYTES) : cmd_alloc_len;
  assign len_c = (alloc_c < 24'(avail_c)) ? alloc_c[8:0] : avail_c;
  assign cmd_ready = state_q == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  logic adv;
  assign adv = !din_valid_q || din_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      src_q <= SRC_DIR;
      pos_q <= 9'h000;
      cnt_q <= 9'h000;
      buf_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (fire) begin
            src_q <= is_cap ? SRC_CAP : (is_hist ? SRC_HIST : SRC_DIR);
            pos_q <= is_hist ? cmd_buffer_offset[8:0] : 9'h000;
            cnt_q <= (err_c || is_clr) ? 9'h000 : len_c;
            buf_q <= hist_idx[1:0];
            state_q <= (err_c || is_clr) ? ST_DONE : ST_XFER;
          end
        end
        ST_XFER: begin
          if (adv) begin
            if (cnt_q != 9'h000) begin
              pos_q <= pos_q + 9'h001;
              cnt_q <= cnt_q - 9'h001;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sense data, held until the next command
  always_ff @(posedge clk) begin
    if (rst) begin
      check_q <= 1'b0;
      key_q <= 4'h0;
      asc_q <= 8'h00;
      ascq_q <= 8'h00;
    end else if (fire) begin
      check_q <= err_c;
      key_q <= err_c ? `SK_ILLEGAL_REQ : 4'h0;
      if (oip_c) begin
        asc_q <= `ASC_OIP;
        ascq_q <= `ASCQ_OIP;
      end else if (bad_op_c) begin
        asc_q <= `ASC_INVALID_OP;
        ascq_q <= 8'h00;
      end else if (bad_id_c || bad_off_c) begin
        asc_q <= `ASC_INVALID_CDB;
        ascq_q <= 8'h00;
      end else begin
        asc_q <= 8'h00;
        ascq_q <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // snapshot and nexus state
  logic ok_rb;
  assign ok_rb = fire && is_rb && !err_c;

  always_ff @(posedge clk) begin
    if (rst) begin
      snap_q <= 1'b0;
      nexus_q <= 1'b0;
      nexus_id_q <= 8'h00;
      retrieved_q <= 1'b0;
      snapshot_source_field <= 2'h0;
    end else if (ok_rb) begin
      if (cmd_buffer_id == `ID_DIR_SNAP || cmd_buffer_id == `ID_DIR_BOTH) begin
        snap_q <= 1'b1;
        retrieved_q <= 1'b0;
        snapshot_source_field <= `SRC_BY_HOST;
      end
      if (cmd_buffer_id == `ID_DIR_NEXUS || cmd_buffer_id == `ID_DIR_BOTH) begin
        nexus_q <= 1'b1;
        nexus_id_q <= cmd_nexus;
      end
      if (is_clr) begin
        nexus_q <= 1'b0;
      end
      if (cmd_buffer_id == `ID_CLR_ALL) begin
        snap_q <= 1'b0;
        retrieved_q <= 1'b0;
        snapshot_source_field <= 2'h0;
      end
      if (is_hist) begin
        retrieved_q <= 1'b1;
      end
    end
  end

  assign clear_supported_flag = 1'b1;
  assign snapshot_valid = snap_q;
  assign nexus_valid = nexus_q;
  assign snapshot_retrieved_flag = retrieved_q;

  ////////////////////////////////////////////////////////////////////////
  // history store; writes freeze while a snapshot stands so it stays exact
  assign hist_wr_ready = !snap_q;
  assign hp.wr_en = hist_wr_valid && !snap_q;
  assign hp.wr_addr = hist_wr_addr;
  assign hp.wr_data = hist_wr_data;
  assign hp.rd_addr = {buf_q, pos_q[7:0]};

  hist_store u_store (
    .clk(clk),
    .port(hp.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // reply byte generation
  logic [8:0] dpos;
  logic [2:0] ent;
  logic [31:0] ent_len;
  logic [7:0] ent_id, len_byte, cap_byte, dir_byte, byte_c;

  assign dpos = pos_q - `DIR_HDR_BYTES;
  assign ent = dpos[5:3];
  // first four entries are the directory ids, then the history buffers
  assign ent_id = ent[2] ? (`ID_HIST_FIRST + {6'h00, ent[1:0]}) : {6'h00, ent[1:0]};
  assign ent_len = ent[2] ? 32'(`HIST_BUF_LEN) : 32'(`DIR_BYTES);

  word_byte_sel u_len_sel (
    .word(ent_len),
    .idx(dpos[1:0]),
    .byte_out(len_byte)
  );

  // block length is the user-data size supplied outside, protection bytes excluded
  word_byte_sel u_cap_sel (
    .word(pos_q[2] ? block_length : max_lba),
    .idx(pos_q[1:0]),
    .byte_out(cap_byte)
  );

  always_comb begin
    dir_byte = 8'h00;
    if (pos_q < 9'h008) begin
      dir_byte = VENDOR_ID[8'(63 - 8 * pos_q[2:0]) -: 8];
    end else if (pos_q == `DIR_POS_VERSION) begin
      dir_byte = `DIR_VERSION;
    end else if (pos_q == `DIR_POS_FLAGS) begin
      dir_byte[`FLAG_RETRIEVED_BIT] = retrieved_q;
      dir_byte[`FLAG_SOURCE_LSB +: 2] = snapshot_source_field;
      dir_byte[`FLAG_CLEAR_SUPPORTED_FLAG_BIT] = clear_supported_flag;
    end else if (pos_q == `DIR_POS_LEN_LO) begin
      dir_byte = `DIR_LEN_LO;
    end else if (pos_q >= `DIR_HDR_BYTES) begin
      if (dpos[2:0] == 3'h0) begin
        dir_byte = ent_id;
      end else if (dpos[2]) begin
        dir_byte = len_byte;
      end
    end
  end

  always_comb begin
    unique case (src_q)
      SRC_DIR: byte_c = dir_byte;
      SRC_HIST: byte_c = hp.rd_data;
      SRC_CAP: byte_c = cap_byte;
      default: byte_c = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      din_valid_q <= 1'b0;
      din_last_q <= 1'b0;
      din_data_q <= 8'h00;
    end else if (state_q == ST_XFER && adv) begin
      din_valid_q <= cnt_q != 9'h000;
      din_last_q <= cnt_q == 9'h001;
      if (cnt_q != 9'h000) begin
        din_data_q <= byte_c;
      end
    end
  end

  assign din_valid = din_valid_q;
  assign din_last = din_last_q;
  assign din_data = din_data_q;
  assign done = state_q == ST_DONE;
  assign check_condition = check_q;
  assign sense_key = key_q;
  assign sense_asc = asc_q;
  assign sense_ascq = ascq_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [8:0] shown_pos;
  assign shown_pos = pos_q - 9'h001;

  busy_nexus_a: assert property (fire && oip_c |=> check_q && asc_q == `ASC_OIP && ascq_q == `ASCQ_OIP ##0 done)
    else $error("foreign nexus not refused");
  start_offset_a: assert property (fire && is_hist && !err_c |=> pos_q == $past(cmd_buffer_offset[8:0]))
    else $error("history read does not start at offset");
  bad_offset_a: assert property (fire && !oip_c && !bad_op_c && bad_off_c |=> asc_q == `ASC_INVALID_CDB ##0 done)
    else $error("bad offset accepted");
  dir_length_a: assert property (fire && is_rb && is_dir && !err_c |=> src_q == SRC_DIR && cnt_q <= `DIR_BYTES)
    else $error("directory not returned");
  dir_header_a: assert property (din_valid && src_q == SRC_DIR && shown_pos == `DIR_POS_LEN_LO |-> din_data == `DIR_LEN_LO)
    else $error("directory length byte wrong");
  dir_entry_a: assert property (din_valid && src_q == SRC_DIR && shown_pos == 9'h040 |-> din_data == `ID_HIST_FIRST)
    else $error("first history entry id wrong");
  entry_len_a: assert property (din_valid && src_q == SRC_DIR && shown_pos == 9'h05e |-> din_data == 8'h01)
    else $error("entry length byte wrong");
  hist_byte_a: assert property (state_q == ST_XFER && adv && cnt_q != 9'h000 && src_q == SRC_HIST
    |=> din_valid && din_data == $past(hp.rd_data))
    else $error("history byte not from store");
  unsup_id_a: assert property (fire && !oip_c && bad_id_c |=> check_q && key_q == `SK_ILLEGAL_REQ ##1 state_q == ST_IDLE)
    else $error("unsupported id accepted");
  hist_bound_a: assert property (state_q == ST_XFER && src_q == SRC_HIST |-> 10'(pos_q) + 10'(cnt_q) <= 10'h100)
    else $error("history read past buffer");
  cap_bytes_a: assert property (fire && is_cap |=> src_q == SRC_CAP && cnt_q == `CAP_BYTES)
    else $error("capacity reply size wrong");
  cap_order_a: assert property (din_valid && src_q == SRC_CAP && shown_pos == 9'h004 |-> din_data == block_length[31:24])
    else $error("block length not msb first");
  snap_freeze_a: assert property (snap_q && $past(snap_q) && hp.rd_addr == $past(hp.rd_addr)
    |-> hp.rd_data == $past(hp.rd_data))
    else $error("snapshot overwritten");

  dir_read_c: cover property (fire && is_dir && !err_c ##[1:200] done);
  hist_read_c: cover property (fire && is_hist && !err_c ##[1:300] done);
  cap_read_c: cover property (fire && is_cap ##[1:20] din_last && din_ready);
  refused_c: cover property (fire && oip_c);
endmodule
`default_nettype wire

// ==== bench/host_sink.sv ====
// host-side data-in sink with prompt or stalling acceptance
`timescale 1ns/100ps
`default_nettype none
module host_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data-in stream
  input wire logic din_valid,
  input wire logic [7:0] din_data,
  input wire logic din_last,
  output logic din_ready,
  // pacing
  input wire logic slow
);
  logic [7:0] rx_q [$];
  int last_at = -1;
  initial din_ready = 1'b0;
  always @(posedge clk) begin
    // random stalls force the source to hold its byte across gaps
    din_ready <= !rst && (!slow || ($urandom_range(3) == 0));
    if (!rst && din_valid && din_ready) begin
      if (din_last) last_at = rx_q.size();
      rx_q.push_back(din_data);
    end
  end
endmodule
`default_nettype wire

// ==== bench/error_history_and_capacity_reply_tb.sv ====
// self-checking bench for the error-history and capacity command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "ehcr_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module error_history_and_capacity_reply_tb;
  localparam logic [63:0] VID = 64'h4142_4344_4546_4748; // arbitrary value
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, slow = 1'b0, hist_wr_valid = 1'b0;
  logic cmd_ready, din_valid, din_last, din_ready, done, check_condition, hist_wr_ready;
  logic [7:0] cmd_opcode = 8'h00, cmd_buffer_id = 8'h00, cmd_nexus = 8'h00, hist_wr_data = 8'h00;
  logic [4:0] cmd_mode = 5'h00;
  logic [23:0] cmd_buffer_offset = 24'h000000, cmd_alloc_len = 24'h000000;
  logic [31:0] max_lba = 32'h00000000, block_length = 32'h00000000;
  logic [9:0] hist_wr_addr = 10'h000;
  logic [7:0] din_data, sense_asc, sense_ascq;
  logic [3:0] sense_key;
  logic snapshot_valid, nexus_valid, snapshot_retrieved_flag;
  int mismatches = 0, n_tests = 0, cycles = 0;
  // model state
  logic [7:0] mem [1024];
  logic [7:0] exp_q [$];
  logic [3:0] ek;
  logic [7:0] ea, eq, m_nx;
  logic m_snap = 1'b0, m_nx_ok = 1'b0, m_ret = 1'b0;
  logic [7:0] bad_ids [4] = '{8'h14, 8'h04, 8'hf0, 8'hef};
  logic [7:0] foreign_ids [3] = '{8'h10, 8'h00, 8'hfe};

  ehcr_cmd #(.VENDOR_ID(VID)) i_ehcr_cmd (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_mode,
    .cmd_buffer_id, .cmd_buffer_offset, .cmd_alloc_len, .cmd_nexus, .din_valid, .din_data, .din_last,
    .din_ready, .done, .check_condition, .sense_key, .sense_asc, .sense_ascq, .max_lba, .block_length,
    .hist_wr_valid, .hist_wr_ready, .hist_wr_addr, .hist_wr_data, .snapshot_valid, .nexus_valid,
    .snapshot_retrieved_flag);
  host_sink i_host_sink (.clk, .rst, .din_valid, .din_data, .din_last, .din_ready, .slow);

  initial forever #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic predict(input logic [7:0] op, input logic [4:0] md, input logic [7:0] id,
                         input logic [23:0] off, input logic [23:0] al, input logic [7:0] nx);
    exp_q = {};
    {ek, ea, eq} = 20'h00000;
    if (op == `OP_READ_CAP10) begin
      for (int i = 0; i < 8; i++) exp_q.push_back(i < 4 ? max_lba[31-8*i -: 8] : block_length[63-8*i -: 8]);
    end else if (op != `OP_READ_BUFFER || md != `MODE_ERR_HIST) begin
      {ek, ea} = 12'h520;
    end else if (m_nx_ok && nx != m_nx && m_snap && id != 8'h02 && id != 8'h03) begin
      {ek, eq} = 12'h516;
    end else if (id > 8'h03 && (id < 8'h10 || id > 8'h13) && id < 8'hfe) begin
      {ek, ea} = 12'h524;
    end else if (id < 8'hfe && (id <= 8'h03 ? off != 24'h0 : off > 24'h0000ff)) begin
      {ek, ea} = 12'h524;
    end else if (id >= 8'hfe) begin
      m_nx_ok = 1'b0;
      if (id[0]) {m_snap, m_ret} = 2'b00;
    end else if (id <= 8'h03) begin
      if (id[1]) {m_nx_ok, m_nx} = {1'b1, nx};
      if (id[0]) {m_snap, m_ret} = 2'b10;
      for (int i = 0; i < 8; i++) exp_q.push_back(VID[63-8*i -: 8]);
      exp_q.push_back(8'h00);
      exp_q.push_back({4'h0, m_ret, 1'b0, m_snap, 1'b1});
      for (int i = 10; i < 31; i++) exp_q.push_back(8'h00);
      exp_q.push_back(8'h40);
      for (int k = 0; k < 8; k++) begin
        for (int j = 0; j < 8; j++)
          exp_q.push_back(j == 0 ? 8'(k < 4 ? k : k + 12) : j == 6 ? 8'(k >= 4) : j == 7 && k < 4 ? 8'h60 : 8'h00);
      end
    end else begin
      for (int i = int'(off); i < 256; i++) exp_q.push_back(mem[(id - 8'h10) * 256 + i]);
      m_ret = 1'b1;
    end
    while (op != `OP_READ_CAP10 && exp_q.size() > al) exp_q.pop_back();
  endtask

  task automatic run_cmd(input logic [7:0] op, input logic [4:0] md, input logic [7:0] id,
                         input logic [23:0] off, input logic [23:0] al, input logic [7:0] nx);
    int n;
    n = 0;
    i_host_sink.rx_q.delete();
    i_host_sink.last_at = -1;
    @(posedge clk);
    {cmd_opcode, cmd_mode, cmd_buffer_id, cmd_buffer_offset, cmd_alloc_len, cmd_nexus} <= {op, md, id, off, al, nx};
    cmd_valid <= 1'b1;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    predict(op, md, id, off, al, nx);
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(negedge clk); while (done !== 1'b1 && ++n < 3000);
    if (done !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    `CHK("sense key", ek, sense_key)
    `CHK("sense code", ea, sense_asc)
    `CHK("sense qualifier", eq, sense_ascq)
    `CHK("check condition", ek != 4'h0, check_condition)
    @(negedge clk);
    `CHK("snapshot", m_snap, snapshot_valid)
    `CHK("nexus", m_nx_ok, nexus_valid)
    `CHK("retrieved", m_ret, snapshot_retrieved_flag)
    `CHK("byte count", exp_q.size(), i_host_sink.rx_q.size())
    `CHK("last marker", exp_q.size() - 1, i_host_sink.last_at)
    foreach (exp_q[i]) if (i < i_host_sink.rx_q.size()) `CHK("data byte", exp_q[i], i_host_sink.rx_q[i])
  endtask

  task automatic fill();
    for (int a = 0; a < 1024; a++) begin
      @(posedge clk);
      mem[a] = 8'($urandom());
      {hist_wr_valid, hist_wr_addr, hist_wr_data} <= {1'b1, 10'(a), mem[a]};
    end
    @(posedge clk);
    hist_wr_valid <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'h1056a380));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      max_lba <= $urandom();
      block_length <= r[0] ? 32'h00000200 : $urandom();
      slow <= r[1];
      run_cmd(`OP_READ_CAP10, 5'h00, 8'h00, 24'h0, 24'h0, 8'h01);
    end
    `CHK("write ready", 1'b1, hist_wr_ready)
    fill();
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h03, 24'h0, 24'h0003e8, 8'h05);
    @(posedge clk);
    {hist_wr_valid, hist_wr_addr, hist_wr_data} <= {1'b1, 10'h000, ~mem[0]};
    @(negedge clk);
    `CHK("write ready", 1'b0, hist_wr_ready)
    @(posedge clk);
    hist_wr_valid <= 1'b0;
    slow <= 1'b0;
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h10, 24'h0, 24'h00012c, 8'h05);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h11, 24'(200 + $urandom_range(55)), 24'h14, 8'h05);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h13, 24'h0000ff, 24'h9, 8'h05);
    foreach (foreign_ids[i]) run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, foreign_ids[i], 24'h0, 24'h40, 8'h07);
    slow <= 1'b1;
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h02, 24'h0, 24'h000200, 8'h07);
    foreach (bad_ids[i]) run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, bad_ids[i], 24'h0, 24'h40, 8'h07);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h10, 24'h000100, 24'h40, 8'h07);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h00, 24'h000001, 24'h40, 8'h07);
    run_cmd(8'h12, `MODE_ERR_HIST, 8'h00, 24'h0, 24'h40, 8'h07);
    run_cmd(`OP_READ_BUFFER, 5'h02, 8'h00, 24'h0, 24'h40, 8'h07);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h00, 24'h0, 24'h00000a, 8'h07);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'hff, 24'h000005, 24'h40, 8'h07);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h10, 24'h0, 24'h4, 8'h05);
    run_cmd(`OP_READ_BUFFER, `MODE_ERR_HIST, 8'h00, 24'h0, 24'h000010, 8'h05);
    report_and_stop();
  end
endmodule
`default_nettype wire
